// >>> hdl/ssrc_top.sv
// SPI slave deciding the serial output data of each frame
`timescale 1ns/10ps

module ssrc_top
	import ssrc_pkg::*;
(
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic SERIAL_CLK,
	input wire logic CHIP_SELECT_LOW,
	input wire logic SERIAL_IN_PIN,
	output logic SERIAL_OUT_PIN,
	output logic SERIAL_OUT_OE_N,
	input wire logic [2:0] CUR_MODE,
	input wire ssrc_regs_t SRC_REGS,
	input wire logic ENTER_NORMAL,
	input wire logic [2:0] PREV_MODE,
	input wire logic RESTART_BY_FAILURE,
	input wire logic WD_CFG_13,
	output logic CMD_VALID,
	output ssrc_cmd_t CMD,
	output logic WRITE_STB,
	output logic WD_TRIGGER,
	output logic CLEAR_STB,
	output logic [2:0] CLEAR_SEL
);

`include "ssrc_consts.svh"

	////////////////////////////////////////////////////////////////////////////
	// Reset release

	logic rst_meta;
	logic rst_n;

	// Two-flop release of the asynchronous reset
	always_ff @(posedge CLK or negedge RSTN) begin
		if (!RSTN) begin
			rst_meta <= `SSRC_RST_LOW;
			rst_n <= `SSRC_RST_LOW;
		end else begin
			rst_meta <= `SSRC_RST_HIGH;
			rst_n <= rst_meta;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Link inputs

	logic [`SSRC_LNK_W-1:0] lnk_raw;
	logic [`SSRC_LNK_W-1:0] lnk;

	// Serial clock idles low, chip select idles high, data idles low
	assign lnk_raw = {SERIAL_IN_PIN, CHIP_SELECT_LOW, SERIAL_CLK};

	ssrc_sync3 #(
		.W(`SSRC_LNK_W),
		.RST_VAL(`SSRC_SYNC_RST)
	) u_sync (
		.clk(CLK),
		.rst_n(rst_n),
		.d(lnk_raw),
		.q(lnk)
	);

	////////////////////////////////////////////////////////////////////////////
	// Frame logic

	ssrc_state_t st;
	ssrc_state_t next_st;
	logic sck_rise;
	logic sck_fall;
	logic cs_fall;
	logic cs_rise;
	logic active;
	logic serial_in_pin;
	logic [2:0] ro_sel;
	logic [2:0] auto_mode;
	logic [2:0] auto_sel;

	// Edges of the filtered link lines
	assign sck_rise = lnk[`SSRC_LNK_SCK] && !st.sck_q;
	assign sck_fall = !lnk[`SSRC_LNK_SCK] && st.sck_q;
	assign cs_fall = !lnk[`SSRC_LNK_CS] && st.cs_q;
	assign cs_rise = lnk[`SSRC_LNK_CS] && !st.cs_q;
	assign active = !lnk[`SSRC_LNK_CS] && !st.cs_q;
	assign serial_in_pin = lnk[`SSRC_LNK_SDI];
	// Select field completes with the sixth bit
	assign ro_sel = {serial_in_pin, st.rx[`SSRC_CS_HI-1:`SSRC_CS_LO]};

	// Mode and register of the automatic first frame
	always_comb begin
		auto_mode = PREV_MODE;
		auto_sel = `SSRC_SEL_CONFIG;
		if (PREV_MODE == `SSRC_MODE_SLEEP) begin
			auto_sel = `SSRC_SEL_WAKE;
		end else if (PREV_MODE == `SSRC_MODE_FAILSAFE) begin
			auto_sel = `SSRC_SEL_LIMP;
		end else if (PREV_MODE == `SSRC_MODE_RESTART) begin
			auto_mode = `SSRC_MODE_RESTART;
			if (RESTART_BY_FAILURE && WD_CFG_13) begin
				auto_sel = `SSRC_SEL_LIMP;
			end else begin
				auto_sel = `SSRC_SEL_CONFIG;
			end
		end
	end

	// Next state of the whole block
	always_comb begin
		next_st = st;
		next_st.sck_q = lnk[`SSRC_LNK_SCK];
		next_st.cs_q = lnk[`SSRC_LNK_CS];
		next_st.cmd_valid = 1'b0;
		next_st.write_stb = 1'b0;
		next_st.wd_trig = 1'b0;
		next_st.clr_stb = 1'b0;
		if (cs_fall) begin
			// Load the outgoing frame at the start of the frame
			next_st.bitcnt = `SSRC_BITS_ZERO;
			next_st.ro = 1'b0;
			if (st.first_pend) begin
				next_st.tx = {SRC_REGS[st.first_sel], st.first_sel, st.first_mode};
				next_st.sent_sel = st.first_sel;
				next_st.sent_explicit = 1'b0;
			end else begin
				next_st.tx = {SRC_REGS[st.pend_sel], st.pend_sel, CUR_MODE};
				next_st.sent_sel = st.pend_sel;
				next_st.sent_explicit = 1'b1;
			end
			next_st.serial_out_pin = next_st.tx[0];
			next_st.sdo_oe_n = 1'b0;
		end else if (active) begin
			if (sck_rise && st.bitcnt != `SSRC_BITS_OVER) begin
				// Capture input bits in arrival order
				if (st.bitcnt < `SSRC_BITS_FULL) begin
					next_st.rx[st.bitcnt[3:0]] = serial_in_pin;
				end
				// Read-only swaps in the selected content before bit six goes out
				if (st.bitcnt == `SSRC_BITS_SEL_DONE &&
						st.rx[`SSRC_MS_HI:`SSRC_MS_LO] == `SSRC_MODE_READ_ONLY) begin
					next_st.tx[`SSRC_DATA_HI:`SSRC_DATA_LO] = SRC_REGS[ro_sel];
					next_st.sent_sel = ro_sel;
					next_st.sent_explicit = 1'b1;
					next_st.ro = 1'b1;
				end
				if (st.bitcnt == `SSRC_BITS_FULL) begin
					next_st.bitcnt = `SSRC_BITS_OVER;
				end else begin
					next_st.bitcnt = st.bitcnt + `SSRC_BITS_ONE;
				end
			end
			// Next output bit on the falling serial clock
			if (sck_fall && st.bitcnt < `SSRC_BITS_FULL) begin
				next_st.serial_out_pin = st.tx[st.bitcnt[3:0]];
			end
		end
		if (cs_rise) begin
			next_st.sdo_oe_n = 1'b1;
			next_st.serial_out_pin = 1'b0;
			if (st.bitcnt == `SSRC_BITS_FULL) begin
				// Complete frame: act on it now
				next_st.cmd_valid = 1'b1;
				next_st.cmd = st.rx;
				next_st.wd_trig = 1'b1;
				next_st.first_pend = 1'b0;
				if (st.ro) begin
					next_st.write_stb = 1'b0;
				end else begin
					next_st.write_stb = 1'b1;
					next_st.pend_sel = st.rx[`SSRC_CS_HI:`SSRC_CS_LO];
				end
				// Flags clear only after an explicit request was sent
				if (st.sent_explicit) begin
					next_st.clr_stb = 1'b1;
					next_st.clr_sel = st.sent_sel;
				end
			end
		end
		// Entering normal mode arms the automatic first frame
		if (ENTER_NORMAL) begin
			next_st.first_pend = 1'b1;
			next_st.first_mode = auto_mode;
			next_st.first_sel = auto_sel;
		end
	end

	// State register
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			st <= '0;
			st.cs_q <= 1'b1;
			st.sdo_oe_n <= 1'b1;
			st.bitcnt <= `SSRC_BITS_OVER;
			st.first_mode <= `SSRC_MODE_INIT;
			st.first_sel <= `SSRC_SEL_CONFIG;
			st.pend_sel <= `SSRC_SEL_CONFIG;
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs

	// All outputs straight from the state register
	assign SERIAL_OUT_PIN = st.serial_out_pin;
	assign SERIAL_OUT_OE_N = st.sdo_oe_n;
	assign CMD_VALID = st.cmd_valid;
	assign CMD = st.cmd;
	assign WRITE_STB = st.write_stb;
	assign WD_TRIGGER = st.wd_trig;
	assign CLEAR_STB = st.clr_stb;
	assign CLEAR_SEL = st.clr_sel;

endmodule

// >>> common/ssrc_consts.svh
// Constants of the SPI response control block: frame fields, codes and counts
`ifndef SSRC_CONSTS_SVH
`define SSRC_CONSTS_SVH

// Frame field positions, bit 0 is the first bit on both data lines
`define SSRC_MS_LO 0
`define SSRC_MS_HI 2
`define SSRC_CS_LO 3
`define SSRC_CS_HI 5
`define SSRC_DATA_LO 6
`define SSRC_DATA_HI 15

// Bit counter values
`define SSRC_BITS_FULL 5'h10
`define SSRC_BITS_SEL_DONE 5'h05
`define SSRC_BITS_OVER 5'h1f
`define SSRC_BITS_ZERO 5'h00
`define SSRC_BITS_ONE 5'h01

// Mode codes of the mode selection field
`define SSRC_MODE_INIT 3'h0
`define SSRC_MODE_RESTART 3'h1
`define SSRC_MODE_FAILSAFE 3'h2
`define SSRC_MODE_SLEEP 3'h3
`define SSRC_MODE_NORMAL 3'h4
`define SSRC_MODE_READ_ONLY 3'h7

// Configuration select codes
`define SSRC_SEL_CONFIG 3'h0
`define SSRC_SEL_WAKE 3'h1
`define SSRC_SEL_WDOG 3'h6
`define SSRC_SEL_LIMP 3'h7

// Positions of the link lines inside the synchroniser
`define SSRC_LNK_SCK 0
`define SSRC_LNK_CS 1
`define SSRC_LNK_SDI 2
`define SSRC_LNK_W 3

// Reset values
// Synchroniser reset: serial clock low, chip select high, data low
`define SSRC_SYNC_RST 3'h2
`define SSRC_RST_LOW 1'b0
`define SSRC_RST_HIGH 1'b1

`endif

// >>> common/ssrc_pkg.sv
// Types shared by the SPI response control block
package ssrc_pkg;

	// Register content carried in a frame
	typedef logic [9:0] ssrc_word_t;

	// One frame: mode field in the low bits, content in the high bits
	typedef struct packed {
		ssrc_word_t data;
		logic [2:0] csel;
		logic [2:0] mode;
	} ssrc_cmd_t;

	// All eight selectable registers
	typedef ssrc_word_t [7:0] ssrc_regs_t;

	// Whole state of the top module
	typedef struct packed {
		logic sck_q;
		logic cs_q;
		logic [15:0] rx;
		logic [15:0] tx;
		logic [4:0] bitcnt;
		logic ro;
		logic first_pend;
		logic [2:0] first_mode;
		logic [2:0] first_sel;
		logic [2:0] pend_sel;
		logic [2:0] sent_sel;
		logic sent_explicit;
		logic serial_out_pin;
		logic sdo_oe_n;
		logic cmd_valid;
		ssrc_cmd_t cmd;
		logic write_stb;
		logic wd_trig;
		logic clr_stb;
		logic [2:0] clr_sel;
	} ssrc_state_t;

endpackage

// >>> hdl/ssrc_sync3.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/10ps

module ssrc_sync3 #(
	parameter int W = 3,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} ssrc_sync_t;

	ssrc_sync_t st;
	ssrc_sync_t next_st;

	// Shift the chain; a bit is taken once stages two and three agree
	always_comb begin
		next_st = st;
		next_st.s1 = d;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < W; i++) begin
			if (st.s2[i] == st.s3[i]) begin
				next_st.q[i] = st.s3[i];
			end
		end
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
		end else begin
			st <= next_st;
		end
	end

	assign q = st.q;

endmodule

// >>> dv/ssrc_asserts.sv
// Port checks of the SPI response block
`timescale 1ns/10ps
module ssrc_chk
	import ssrc_pkg::*;
(
	input wire logic CLK,
	input wire logic RSTN,
	input wire logic CHIP_SELECT_LOW,
	input wire logic SERIAL_OUT_PIN,
	input wire logic SERIAL_OUT_OE_N,
	input wire logic CMD_VALID,
	input wire ssrc_cmd_t CMD,
	input wire logic WRITE_STB,
	input wire logic WD_TRIGGER,
	input wire logic CLEAR_STB,
	input wire logic [2:0] CLEAR_SEL
);
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RSTN);
	// Strobes tied to their command, command held between pulses, output off when idle
	a_ro_no_write: assert property (CMD_VALID && CMD.mode == 3'h7 |-> !WRITE_STB)
		else $error("write on read-only");
	a_write_has_stb: assert property (CMD_VALID && CMD.mode != 3'h7 |-> WRITE_STB)
		else $error("no write strobe");
	a_wd_every_cmd: assert property (CMD_VALID |-> WD_TRIGGER)
		else $error("no watchdog trigger");
	a_stb_framed: assert property (WRITE_STB || WD_TRIGGER || CLEAR_STB |-> CMD_VALID)
		else $error("strobe without command");
	a_ro_clear_sel: assert property (CMD_VALID && CMD.mode == 3'h7 |-> CLEAR_STB && CLEAR_SEL == CMD.csel)
		else $error("read-only clear wrong");
	a_valid_pulse: assert property (CMD_VALID |=> !CMD_VALID)
		else $error("valid too long");
	a_cmd_holds: assert property (!CMD_VALID |-> $stable(CMD) && $stable(CLEAR_SEL))
		else $error("command changed");
	a_out_idle: assert property (CHIP_SELECT_LOW [*8] |-> SERIAL_OUT_OE_N && !SERIAL_OUT_PIN)
		else $error("output driven idle");
	cover property (CMD_VALID && CMD.mode == 3'h7);
	cover property (WRITE_STB && CLEAR_STB);
	cover property (!SERIAL_OUT_OE_N && SERIAL_OUT_PIN);
endmodule

bind ssrc_top ssrc_chk u_chk (.CLK, .RSTN, .CHIP_SELECT_LOW, .SERIAL_OUT_PIN, .SERIAL_OUT_OE_N,
	.CMD_VALID, .CMD, .WRITE_STB, .WD_TRIGGER, .CLEAR_STB, .CLEAR_SEL);

// >>> dv/ssrc_spi_master.sv
// Behavioural SPI controller on the far side of the block
`timescale 1ns/10ps
module ssrc_spi_master (
	output logic sck,
	output logic cs_n,
	output logic serial_in_pin,
	input wire logic sdo_pin,
	input wire logic sdo_oe_n
);
	// Idle: clock still and low, select high, data at its pull-down level
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		serial_in_pin = 1'b0;
	end
	// Frame of n clocks, bit 0 first, answer taken just before each fall
	task automatic frame(input logic [15:0] tx, input int n, output logic [15:0] rx);
		int i;
		#13 cs_n = 1'b0;
		#160;
		for (i = 0; i < n; i++) begin
			serial_in_pin = tx[i%16];
			#160 sck = 1'b1;
			#160 rx[i%16] = sdo_oe_n ? 1'bz : sdo_pin;
			sck = 1'b0;
		end
		#160 cs_n = 1'b1;
		serial_in_pin = 1'b0;
		#480;
	endtask
endmodule

// >>> dv/tb_sbc_spi_response_control.sv
// Self-checking bench of the SPI response block
`timescale 1ns/10ps
module tb_sbc_spi_response_control
	import ssrc_pkg::*;
;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic en = 1'b0;
	logic rf = 1'b0;
	logic w13 = 1'b0;
	logic [2:0] cm = 3'h4;
	logic [2:0] pm = 3'h0;
	ssrc_regs_t regs = '0;
	logic sck, cs_n, serial_in_pin, serial_out_pin, oe_n, vld, wr, wd, clr;
	logic [2:0] clr_sel;
	ssrc_cmd_t cmd;
	logic [21:0] seen;
	logic [2:0] pend = 3'h0;
	logic [2:0] csq = 3'h0;
	logic expl = 1'b0;
	logic [31:0] seed = 32'h8;
	logic [17:0] t_pm = {3'h0, 3'h1, 3'h1, 3'h1, 3'h2, 3'h3};
	logic [5:0] t_f = 6'h14;
	logic [5:0] t_w = 6'h04;
	int nv = 0;
	int n_fail = 0;
	int n_checks = 0;

	initial forever #20 clk = ~clk;

	ssrc_top u_dut (.CLK(clk), .RSTN(rst_n), .SERIAL_CLK(sck), .CHIP_SELECT_LOW(cs_n),
		.SERIAL_IN_PIN(serial_in_pin), .SERIAL_OUT_PIN(serial_out_pin), .SERIAL_OUT_OE_N(oe_n), .CUR_MODE(cm),
		.SRC_REGS(regs), .ENTER_NORMAL(en), .PREV_MODE(pm), .RESTART_BY_FAILURE(rf),
		.WD_CFG_13(w13), .CMD_VALID(vld), .CMD(cmd), .WRITE_STB(wr), .WD_TRIGGER(wd),
		.CLEAR_STB(clr), .CLEAR_SEL(clr_sel));
	ssrc_spi_master u_mst (.sck(sck), .cs_n(cs_n), .serial_in_pin(serial_in_pin), .sdo_pin(serial_out_pin), .sdo_oe_n(oe_n));

	// Record the strobes of each completed frame
	always @(posedge clk) begin
		if (vld === 1'b1) begin
			nv <= nv + 1;
			seen <= {wr, wd, clr, clr_sel, cmd};
		end
	end
	////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Register the first frame carries after each earlier mode
	function automatic logic [2:0] first_sel(input logic [2:0] p, input logic f, input logic w);
		if (p == 3'h3) return 3'h1;
		if (p == 3'h2 || (p == 3'h1 && f && w)) return 3'h7;
		return 3'h0;
	endfunction
	task automatic check(input logic [21:0] got, input logic [21:0] exp);
		n_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch at %0t: saw %h expected %h", $time, got, exp);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d failures %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// One frame from the controller, then answer and strobes compared if it has 16 clocks, else a check that no command came
	task automatic run(input logic [2:0] cs, input logic [2:0] md, input logic [2:0] om,
		input logic first, input int n);
		logic [15:0] tx;
		logic [15:0] rx;
		logic ro;
		logic c;
		int n0;
		tx = 16'(rnd());
		tx[5:0] = {cs, md};
		ro = (md == 3'h7);
		c = ro | (expl & !first);
		n0 = nv;
		u_mst.frame(tx, n, rx);
		if (n != 16) begin
			check(22'(nv - n0), 22'h0);
			return;
		end
		check(22'(rx), 22'({regs[ro ? cs : pend], pend, om}));
		check(22'(nv - n0), 22'h1);
		if (c) csq = ro ? cs : pend;
		check(seen, {!ro, 1'b1, c, csq, tx});
		if (!ro) begin
			pend = cs;
			expl = 1'b1;
		end
	endtask

	// Reset, each way into normal operation, then a random mix
	initial begin
		int i;
		logic [31:0] r;
		logic [2:0] keep;
		repeat (12) @(posedge clk);
		rst_n <= 1'b1;
		repeat (10) @(posedge clk);
		for (i = 0; i < 6; i++) begin
			@(posedge clk);
			en <= 1'b1;
			regs <= 80'({rnd(), rnd(), rnd()});
			pm <= t_pm[i*3+:3];
			rf <= t_f[i];
			w13 <= t_w[i];
			@(posedge clk);
			en <= 1'b0;
			pend = first_sel(t_pm[i*3+:3], t_f[i], t_w[i]);
			run(3'h0, 3'h4, 3'h0, 1'b1, 15 + 2 * (i % 2));
			run(3'(i), 3'h4, t_pm[i*3+:3], 1'b1, 16);
		end
		// Hand-picked: read-only as the first frame, then a plain read-only
		@(posedge clk);
		en <= 1'b1;
		pm <= 3'h3;
		@(posedge clk);
		en <= 1'b0;
		keep = pend;
		pend = first_sel(3'h3, 1'b0, 1'b0);
		run(3'h6, 3'h7, 3'h3, 1'b1, 16);
		pend = keep;
		run(3'h2, 3'h7, 3'h4, 1'b0, 16);
		for (i = 0; i < 24; i++) begin
			r = rnd();
			@(posedge clk);
			regs <= 80'({rnd(), rnd(), rnd()});
			cm <= r[10:8];
			@(posedge clk);
			run(r[5:3], (r[1:0] == 2'h0) ? 3'h7 : 3'(r[4:2] % 7), r[10:8], 1'b0, 16);
		end
		stop_test();
	end
	initial begin
		#1ms;
		n_fail++;
		stop_test();
	end
endmodule
